//--- include/wlts_defs.svh
// register offsets, field positions, reset values and the soft reset key for the wiper lock/terminal/sync bank
`ifndef WLTS_DEFS_SVH
`define WLTS_DEFS_SVH

`define WLTS_ADDR_VWIPER0   5'h00
`define WLTS_ADDR_VWIPER1   5'h01
`define WLTS_ADDR_NVWIPER0  5'h02
`define WLTS_ADDR_NVWIPER1  5'h03
`define WLTS_ADDR_GPDATA0   5'h04
`define WLTS_ADDR_GPDATA1   5'h05
`define WLTS_ADDR_GPDATA2   5'h06
`define WLTS_ADDR_STATUS    5'h08
`define WLTS_ADDR_LOCK      5'h09
`define WLTS_ADDR_TERM      5'h0a
`define WLTS_ADDR_SYNC      5'h0b
`define WLTS_ADDR_RESET     5'h0d

`define WLTS_LOCK_V_BIT     0
`define WLTS_LOCK_NV_BIT    1
`define WLTS_SYNC_WR_BIT    0
`define WLTS_SYNC_ID_BIT    1
`define WLTS_SYNC_LAT_BIT   2
`define WLTS_STAT_COMMAND_ERROR_FLAG_BIT 4

`define WLTS_LOCK_RESET     2'h0
`define WLTS_TERM_RESET     6'h00
`define WLTS_SYNC_RESET     3'h0
`define WLTS_WIPER_RESET    10'h200
`define WLTS_SOFT_RESET_KEY 8'ha5

`endif

//--- include/wlts_pkg.sv
// types shared by the wiper lock/terminal/sync bank
package wlts_pkg;
  typedef enum logic [1:0] {
    WLTS_CMD_WRITE = 2'b00,
    WLTS_CMD_INC   = 2'b01,
    WLTS_CMD_DEC   = 2'b10,
    WLTS_CMD_READ  = 2'b11
  } wlts_cmd_t;

  typedef struct packed {
    logic        valid;
    wlts_cmd_t   cmd;
    logic [4:0]  addr;
    logic [15:0] data;
  } wlts_req_t;

  typedef struct packed {
    logic        done;
    logic        ack;
    logic [15:0] rdata;
  } wlts_rsp_t;

  typedef struct packed {
    logic [9:0] ch1;
    logic [9:0] ch0;
  } wlts_wipers_t;
endpackage

//--- rtl/wlts_regs.sv
// lock, terminal connect and wiper sync register bank with volatile wipers and ladder latch
//
// request side
//   one request per valid cycle, no back-pressure
//   answer one cycle later on rsp_out: done, ack, read data
//   read data holds until the next accepted read
//
// address map as seen on req_in.addr
//   00h, 01h volatile wipers
//   02h..06h nonvolatile wipers and general data, kept outside
//   08h status, only the error bit lives here
//   09h lock, 0ah terminal control, 0bh sync, 0dh reset key
//
// refusal
//   one legality decision feeds both the spi error flag and the i2c ack
//   a refused request changes no addressed register and raises no strobe
//   spi mode only: the error flag is set the edge after the refusal
//
// wipers and ladders
//   wiper registers hold what the host wrote or stepped
//   ladder outputs copy the wipers one cycle later while latch hold is clear
//   while latch hold is set the ladders keep their last position
//   steps saturate at zero and full scale, never wrap
//
// resets
//   rstn_in resets everything, wipers and ladders to 200h and the rest to zero, sampled on the clock
//   the soft reset strobe clears terminals and sync and sets wipers and ladders to 200h
//   lock bits and the error flag survive a soft reset
//
// outputs
//   lock bits and terminal bits come straight from their registers
//   disconnect outputs are high while a terminal is cut from its ladder
//   soft_reset_out is a one-cycle pulse for the rest of the device
//   nv_write_out is a one-cycle pulse toward the nonvolatile store
//
// timing
//   every addressed register updates on the edge that takes the request
//   a read in the cycle after a write returns the new value
//   ladders settle two edges after the request that moved the wiper
//
// limitations
//   the nonvolatile store must take its write strobe in one cycle
//   no busy indication from the store is modelled
//   spi_mode_in is taken as a level and may change between requests
//   status bits other than the error flag read as zero
//
// Contract
// - lock register takes only write and read; other commands flag error or nack
// - while a lock bit is set, writes leave protected registers unchanged
// - commands altering a locked register flag error in spi, nack in i2c
// - nonvolatile lock bit 1 protects both nv wipers and three gp registers
// - volatile lock bit 0 protects both volatile wipers and terminal control
// - lock register bits 15 to 2 read as zero
// - terminal control at 0ah, bits 5..3 channel 1, bits 2..0 channel 0
// - terminal bit set disconnects its pin, cleared connects it
// - power-on or software reset clears all terminal bits
// - terminal control bits 15 to 6 read as zero
// - reading terminal control returns present switch state
// - increment or decrement to terminal or sync register is an error
// - sync settings act on volatile wipers only
// - sync at 0bh: bit 2 latch hold, bit 1 joint step, bit 0 joint write
// - all sync bits clear: only addressed wiper changes, ladder follows at once; here the ladder follows one cycle later
// - joint step: step both wipers from own values; writes stay single
// - joint write: write loads both wipers; steps stay single
// - latch hold set: ladders frozen until a write clears latch hold
// - latch hold clear: every wiper change reaches ladders at once; here the ladders copy the wipers one cycle later
// - reading sync returns latch hold, joint step, joint write
// - command error flag sticks until status register is read (spi only)
// - writing key a5h to reset register performs a software reset
`timescale 1ns/10ps
`default_nettype none
`include "wlts_defs.svh"

module wlts_regs
  import wlts_pkg::*;
#(
  parameter int WIPER_W = 10
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         spi_mode_in,
  input  wire wlts_req_t    req_in,
  output var  wlts_rsp_t    rsp_out,
  output logic              nonvolatile_write_lock_out,
  output logic              volatile_write_lock_out,
  output logic              ch1_term_a_disconnect_out,
  output logic              ch1_term_w_disconnect_out,
  output logic              ch1_term_b_disconnect_out,
  output logic              ch0_term_a_disconnect_out,
  output logic              ch0_term_w_disconnect_out,
  output logic              ch0_term_b_disconnect_out,
  output var  wlts_wipers_t ladder_out,
  output logic              nv_write_out,
  output logic [4:0]        nv_addr_out,
  output logic [WIPER_W-1:0] nv_data_out,
  output logic              command_error_flag_out,
  output logic              soft_reset_out
);

  // stored register state
  logic [1:0]         lock_bits;
  logic [5:0]         terminal_connect_ctrl;
  logic [2:0]         wiper_sync_ctrl;
  logic [WIPER_W-1:0] vwiper0;
  logic [WIPER_W-1:0] vwiper1;
  logic               command_error_flag;
  logic               soft_reset;

  // request decode
  logic               cmd_ok;
  logic               is_wiper;
  logic               nv_target;
  logic               v_target;
  logic               do_write;
  logic               do_step;
  logic [15:0]        next_rdata;

  // saturating one-step move; wipers stop at zero and full scale
  function automatic logic [WIPER_W-1:0] step_wiper(input logic [WIPER_W-1:0] w, input logic up);
    logic [WIPER_W-1:0] r;
    r = w;
    if (up) begin
      if (w != {WIPER_W{1'b1}}) begin
        r = w + 1'b1;
      end
    end else begin
      if (w != '0) begin
        r = w - 1'b1;
      end
    end
    return r;
  endfunction

  // register category decode
  // nonvolatile category spans 02h to 06h
  // volatile category is both wipers plus terminal control
  // lock, sync and status belong to neither, so the lock never locks itself
  always_comb begin
    is_wiper  = (req_in.addr == `WLTS_ADDR_VWIPER0) || (req_in.addr == `WLTS_ADDR_VWIPER1);
    nv_target = (req_in.addr >= `WLTS_ADDR_NVWIPER0) && (req_in.addr <= `WLTS_ADDR_GPDATA2);
    v_target  = is_wiper || (req_in.addr == `WLTS_ADDR_TERM);
  end

  // command legality; one decision covers both spi error and i2c nack
  always_comb begin
    cmd_ok = 1'b1;
    case (req_in.cmd)
      WLTS_CMD_READ: begin
        // reset register is write-only
        cmd_ok = (req_in.addr != `WLTS_ADDR_RESET);
      end
      WLTS_CMD_WRITE: begin
        if (nv_target && lock_bits[`WLTS_LOCK_NV_BIT]) begin
          cmd_ok = 1'b0;
        end
        if (v_target && lock_bits[`WLTS_LOCK_V_BIT]) begin
          cmd_ok = 1'b0;
        end
        // status is read only
        // reset key register takes any value, only the key acts
        if (req_in.addr == `WLTS_ADDR_STATUS) begin
          cmd_ok = 1'b0;
        end
      end
      default: begin
        // no steps on term or sync
        // a step on a locked wiper is also refused
        cmd_ok = is_wiper && !lock_bits[`WLTS_LOCK_V_BIT];
      end
    endcase
  end

  assign do_write = req_in.valid && cmd_ok && (req_in.cmd == WLTS_CMD_WRITE);
  assign do_step  = req_in.valid && cmd_ok && ((req_in.cmd == WLTS_CMD_INC) || (req_in.cmd == WLTS_CMD_DEC));

  // software reset strobe, one cycle, raised by the key only
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= do_write && (req_in.addr == `WLTS_ADDR_RESET) &&
                    (req_in.data[7:0] == `WLTS_SOFT_RESET_KEY);
    end
  end

  // lock register; soft reset does not unlock, matching reset register scope
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      lock_bits <= `WLTS_LOCK_RESET;
    end else if (do_write && (req_in.addr == `WLTS_ADDR_LOCK)) begin
      lock_bits <= req_in.data[1:0];
    end
  end

  // terminal control
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || soft_reset) begin
      terminal_connect_ctrl <= `WLTS_TERM_RESET;
    end else if (do_write && (req_in.addr == `WLTS_ADDR_TERM)) begin
      terminal_connect_ctrl <= req_in.data[5:0];
    end
  end

  // sync control
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || soft_reset) begin
      wiper_sync_ctrl <= `WLTS_SYNC_RESET;
    end else if (do_write && (req_in.addr == `WLTS_ADDR_SYNC)) begin
      // latch hold, joint step, joint write
      wiper_sync_ctrl <= req_in.data[2:0];
    end
  end

  // volatile wipers; nv registers live outside, so sync never touches them
  // joint step and joint write bits reach only these two registers
  // a write and a step never meet in one request
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || soft_reset) begin
      vwiper0 <= `WLTS_WIPER_RESET;
      vwiper1 <= `WLTS_WIPER_RESET;
    end else if (do_write && is_wiper) begin
      if (wiper_sync_ctrl[`WLTS_SYNC_WR_BIT] || (req_in.addr == `WLTS_ADDR_VWIPER0)) begin
        vwiper0 <= req_in.data[WIPER_W-1:0];
      end
      if (wiper_sync_ctrl[`WLTS_SYNC_WR_BIT] || (req_in.addr == `WLTS_ADDR_VWIPER1)) begin
        vwiper1 <= req_in.data[WIPER_W-1:0];
      end
    end else if (do_step) begin
      if (wiper_sync_ctrl[`WLTS_SYNC_ID_BIT] || (req_in.addr == `WLTS_ADDR_VWIPER0)) begin
        vwiper0 <= step_wiper(vwiper0, req_in.cmd == WLTS_CMD_INC);
      end
      if (wiper_sync_ctrl[`WLTS_SYNC_ID_BIT] || (req_in.addr == `WLTS_ADDR_VWIPER1)) begin
        vwiper1 <= step_wiper(vwiper1, req_in.cmd == WLTS_CMD_INC);
      end
    end
  end

  // ladder positions follow wipers unless held
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || soft_reset) begin
      ladder_out <= '{ch1: `WLTS_WIPER_RESET, ch0: `WLTS_WIPER_RESET};
    end else if (!wiper_sync_ctrl[`WLTS_SYNC_LAT_BIT]) begin
      // follow one cycle after the wiper
      // release happens once a write clears latch hold
      ladder_out <= '{ch1: vwiper1, ch0: vwiper0};
    end
  end

  // sticky error flag; a new error in the clearing cycle wins
  // i2c refusals leave the flag alone; the nack alone reports there
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      command_error_flag <= 1'b0;
    end else if (req_in.valid && !cmd_ok && spi_mode_in) begin
      command_error_flag <= 1'b1;
    end else if (req_in.valid && cmd_ok && (req_in.cmd == WLTS_CMD_READ) &&
                 (req_in.addr == `WLTS_ADDR_STATUS)) begin
      command_error_flag <= 1'b0;
    end
  end

  // nv write strobe toward the nonvolatile store
  // strobe stands one cycle; address and data hold until the next accepted nv write
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      nv_write_out <= 1'b0;
      nv_addr_out  <= 5'h00;
      nv_data_out  <= '0;
    end else begin
      nv_write_out <= do_write && nv_target;
      if (do_write && nv_target) begin
        nv_addr_out <= req_in.addr;
        nv_data_out <= req_in.data[WIPER_W-1:0];
      end
    end
  end

  // read mux; unimplemented bits are zero
  // reset register reads are refused earlier; default keeps zero
  always_comb begin
    next_rdata = 16'h0000;
    case (req_in.addr)
      `WLTS_ADDR_VWIPER0: next_rdata[WIPER_W-1:0] = vwiper0;
      `WLTS_ADDR_VWIPER1: next_rdata[WIPER_W-1:0] = vwiper1;
      `WLTS_ADDR_LOCK: next_rdata[1:0] = lock_bits;
      `WLTS_ADDR_TERM: next_rdata[5:0] = terminal_connect_ctrl;
      `WLTS_ADDR_SYNC: next_rdata[2:0] = wiper_sync_ctrl;
      `WLTS_ADDR_STATUS: next_rdata[`WLTS_STAT_COMMAND_ERROR_FLAG_BIT] = command_error_flag && spi_mode_in;
      default: next_rdata = 16'h0000;
    endcase
  end

  // response one cycle after the request
  // done follows every request, accepted or not
  // rdata is left alone on refusal, so a failed read shows stale data
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out.done <= req_in.valid;
      rsp_out.ack  <= req_in.valid && cmd_ok;
      if (req_in.valid && cmd_ok && (req_in.cmd == WLTS_CMD_READ)) begin
        rsp_out.rdata <= next_rdata;
      end
    end
  end

  // one disconnect pin per bit
  // bit 5 down to bit 0 map ch1 a, w, b then ch0 a, w, b
  assign {ch1_term_a_disconnect_out, ch1_term_w_disconnect_out, ch1_term_b_disconnect_out,
          ch0_term_a_disconnect_out, ch0_term_w_disconnect_out, ch0_term_b_disconnect_out} = terminal_connect_ctrl;
  assign nonvolatile_write_lock_out = lock_bits[`WLTS_LOCK_NV_BIT];
  assign volatile_write_lock_out    = lock_bits[`WLTS_LOCK_V_BIT];
  assign command_error_flag_out     = command_error_flag;
  assign soft_reset_out             = soft_reset;

endmodule
`default_nettype wire

//--- bench/wlts_regs_sva.sv
// concurrent checks on the lock, terminal and sync register bank ports
`timescale 1ns/10ps
`default_nettype none
`include "wlts_defs.svh"
module wlts_regs_sva
  import wlts_pkg::*;
(
  input wire logic         sys_clk_in,
  input wire logic         rstn_in,
  input wire logic         spi_mode_in,
  input wire wlts_req_t    req_in,
  input wire wlts_rsp_t    rsp_out,
  input wire logic         volatile_write_lock_out,
  input wire logic         ch0_term_a_disconnect_out,
  input wire wlts_wipers_t ladder_out,
  input wire logic         command_error_flag_out,
  input wire logic         soft_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // request shapes shared by the properties
  sequence rd_of(logic [4:0] a);
    req_in.valid && req_in.cmd == WLTS_CMD_READ && req_in.addr == a;
  endsequence
  sequence step_to(logic [4:0] a);
    req_in.valid && req_in.cmd inside {WLTS_CMD_INC, WLTS_CMD_DEC} && req_in.addr == a;
  endsequence
  sequence key_wr;
    req_in.valid && req_in.cmd == WLTS_CMD_WRITE && req_in.addr == `WLTS_ADDR_RESET
      && req_in.data[7:0] == `WLTS_SOFT_RESET_KEY;
  endsequence
  resp_done_a: assert property (req_in.valid |=> rsp_out.done)
    else $error("no done after request");
  no_spur_a: assert property (!req_in.valid |=> !rsp_out.done)
    else $error("done without request");
  lock_cmd_a: assert property (step_to(`WLTS_ADDR_LOCK) |=> !rsp_out.ack)
    else $error("step on lock accepted");
  term_step_a: assert property (step_to(`WLTS_ADDR_TERM) ##0 spi_mode_in |=> command_error_flag_out)
    else $error("step on terminal raised no error");
  term_lock_a: assert property (req_in.valid && req_in.cmd == WLTS_CMD_WRITE && req_in.addr == `WLTS_ADDR_TERM
    && volatile_write_lock_out |=> !rsp_out.ack && ch0_term_a_disconnect_out == $past(ch0_term_a_disconnect_out))
    else $error("locked terminal write took effect");
  err_hold_a: assert property (command_error_flag_out && !(req_in.valid && req_in.cmd == WLTS_CMD_READ
    && req_in.addr == `WLTS_ADDR_STATUS) |=> command_error_flag_out)
    else $error("error flag dropped early");
  i2c_flag_a: assert property (!spi_mode_in && !command_error_flag_out |=> !command_error_flag_out)
    else $error("error flag set in i2c mode");
  lock_zero_a: assert property (rd_of(`WLTS_ADDR_LOCK) |=> rsp_out.rdata[15:2] == 14'h0)
    else $error("lock upper bits not zero");
  term_zero_a: assert property (rd_of(`WLTS_ADDR_TERM) |=> rsp_out.rdata[15:6] == 10'h0)
    else $error("terminal upper bits not zero");
  sync_zero_a: assert property (rd_of(`WLTS_ADDR_SYNC) |=> rsp_out.rdata[15:3] == 13'h0)
    else $error("sync upper bits not zero");
  soft_rst_a: assert property (key_wr |=> soft_reset_out ##1 (!ch0_term_a_disconnect_out
    && ladder_out == {`WLTS_WIPER_RESET, `WLTS_WIPER_RESET}))
    else $error("soft reset did not reinitialise");
endmodule
bind wlts_regs wlts_regs_sva i_sva (
  .sys_clk_in, .rstn_in, .spi_mode_in, .req_in, .rsp_out, .volatile_write_lock_out,
  .ch0_term_a_disconnect_out, .ladder_out, .command_error_flag_out, .soft_reset_out
);
`default_nettype wire

//--- bench/wlts_host.sv
// host-side model that launches one register request per go pulse
`timescale 1ns/10ps
`default_nettype none
module wlts_host
  import wlts_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        go_in,
  input  wire wlts_cmd_t   cmd_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [15:0] data_in,
  output var  wlts_req_t   req_out
);
  initial req_out = '0;
  // launch just after an edge; idle fields flip so stale data never looks valid
  always @(posedge sys_clk_in) begin
    req_out <= go_in ? {1'b1, cmd_in, addr_in, data_in} : {1'b0, ~req_out.cmd, ~req_out.addr, ~req_out.data};
  end
endmodule
`default_nettype wire

//--- bench/wiper_lock_terminal_sync_regs_tb.sv
// self-checking bench for the lock, terminal and sync register bank
`timescale 1ns/10ps
`default_nettype none
module wiper_lock_terminal_sync_regs_tb
  import wlts_pkg::*;
;
  typedef struct packed {wlts_cmd_t c; logic [4:0] a; logic [15:0] d; logic k; logic [15:0] r;} wlts_row_t;
  logic         sys_clk_in = 1'b0;
  logic         rstn_in = 1'b0;
  logic         spi_mode = 1'b1;
  logic         go = 1'b0;
  wlts_cmd_t    cmd = WLTS_CMD_READ;
  logic [4:0]   addr = 5'h00;
  logic [15:0]  data = 16'h0000;
  wlts_req_t    req;
  wlts_rsp_t    rsp;
  wlts_wipers_t ladder;
  logic [5:0]   term;
  logic         flag;
  logic [1:0]   lk;
  logic         nvw;
  logic [4:0]   nva;
  logic [9:0]   nvd;
  logic         srst;
  int           error_cnt = 0;
  int           check_count = 0;
  // ordinary cases: command, address, data, ack, read data
  wlts_row_t rows [19] = '{
    {WLTS_CMD_WRITE, 5'h0a, 16'h003f, 1'b1, 16'h0}, {WLTS_CMD_READ, 5'h0a, 16'h0, 1'b1, 16'h003f},
    {WLTS_CMD_INC, 5'h0a, 16'h0, 1'b0, 16'h0}, {WLTS_CMD_DEC, 5'h0b, 16'h0, 1'b0, 16'h0},
    {WLTS_CMD_WRITE, 5'h0b, 16'h0003, 1'b1, 16'h0}, {WLTS_CMD_READ, 5'h0b, 16'h0, 1'b1, 16'h0003},
    {WLTS_CMD_INC, 5'h09, 16'h0, 1'b0, 16'h0}, {WLTS_CMD_WRITE, 5'h0a, 16'hffc0, 1'b1, 16'h0},
    {WLTS_CMD_READ, 5'h0a, 16'h0, 1'b1, 16'h0}, {WLTS_CMD_WRITE, 5'h00, 16'h0100, 1'b1, 16'h0},
    {WLTS_CMD_INC, 5'h01, 16'h0, 1'b1, 16'h0}, {WLTS_CMD_READ, 5'h00, 16'h0, 1'b1, 16'h0101},
    {WLTS_CMD_WRITE, 5'h09, 16'hffff, 1'b1, 16'h0}, {WLTS_CMD_READ, 5'h09, 16'h0, 1'b1, 16'h0003},
    {WLTS_CMD_WRITE, 5'h0a, 16'h0004, 1'b0, 16'h0}, {WLTS_CMD_WRITE, 5'h02, 16'h0001, 1'b0, 16'h0},
    {WLTS_CMD_DEC, 5'h00, 16'h0, 1'b0, 16'h0}, {WLTS_CMD_READ, 5'h0a, 16'h0, 1'b1, 16'h0},
    {WLTS_CMD_WRITE, 5'h09, 16'h0000, 1'b1, 16'h0}};
  always #12.5 sys_clk_in = ~sys_clk_in;
  wlts_host i_host (.sys_clk_in(sys_clk_in), .go_in(go), .cmd_in(cmd), .addr_in(addr), .data_in(data), .req_out(req));
  wlts_regs i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .spi_mode_in(spi_mode), .req_in(req),
    .rsp_out(rsp), .nonvolatile_write_lock_out(lk[1]), .volatile_write_lock_out(lk[0]),
    .ch1_term_a_disconnect_out(term[5]), .ch1_term_w_disconnect_out(term[4]), .ch1_term_b_disconnect_out(term[3]),
    .ch0_term_a_disconnect_out(term[2]), .ch0_term_w_disconnect_out(term[1]), .ch0_term_b_disconnect_out(term[0]),
    .ladder_out(ladder), .nv_write_out(nvw), .nv_addr_out(nva), .nv_data_out(nvd), .command_error_flag_out(flag),
    .soft_reset_out(srst));
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one request through the host model; bounded wait for done
  task automatic xfer(input wlts_cmd_t c, input logic [4:0] a, input logic [15:0] d);
    int n;
    @(posedge sys_clk_in);
    go <= 1'b1;
    cmd <= c;
    addr <= a;
    data <= d;
    @(posedge sys_clk_in);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (rsp.done !== 1'b1 && n < 4);
    if (rsp.done !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(negedge sys_clk_in);
    chk("term", 20'(term), 20'h0);
    chk("ladder", ladder, {10'h200, 10'h200});
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(rows[i].c, rows[i].a, rows[i].d);
      chk("ack", 20'(rsp.ack), 20'(rows[i].k));
      if (rows[i].c == WLTS_CMD_READ) chk("rdata", 20'(rsp.rdata), 20'(rows[i].r));
    end
    chk("flag", 20'(flag), 20'h1);
    chk("ladder", ladder, {10'h101, 10'h101});
    $display("test table done");
    xfer(WLTS_CMD_WRITE, 5'h09, 16'h0002);
    chk("locks", 20'(lk), 20'h2);
    xfer(WLTS_CMD_WRITE, 5'h02, 16'h0123);
    chk("nv strobe", 20'(nvw), 20'h0);
    xfer(WLTS_CMD_WRITE, 5'h09, 16'h0000);
    xfer(WLTS_CMD_WRITE, 5'h02, 16'h0123);
    chk("nv strobe", 20'(nvw), 20'h1);
    chk("nv addr", 20'(nva), 20'h2);
    chk("nv data", 20'(nvd), 20'h123);
    $display("test nv done");
    xfer(WLTS_CMD_WRITE, 5'h0b, 16'h0007);
    xfer(WLTS_CMD_WRITE, 5'h00, 16'h0155);
    repeat (2) @(negedge sys_clk_in);
    chk("ladder", ladder, {10'h101, 10'h101});
    xfer(WLTS_CMD_WRITE, 5'h0b, 16'h0000);
    repeat (2) @(negedge sys_clk_in);
    chk("ladder", ladder, {10'h155, 10'h155});
    xfer(WLTS_CMD_WRITE, 5'h01, 16'h0020);
    repeat (2) @(negedge sys_clk_in);
    chk("ladder", ladder, {10'h020, 10'h155});
    xfer(WLTS_CMD_READ, 5'h08, 16'h0000);
    chk("status", 20'(rsp.rdata[4]), 20'h1);
    @(negedge sys_clk_in);
    chk("flag", 20'(flag), 20'h0);
    $display("test latch done");
    @(posedge sys_clk_in);
    spi_mode <= 1'b0;
    xfer(WLTS_CMD_INC, 5'h0a, 16'h0000);
    chk("ack", 20'(rsp.ack), 20'h0);
    @(negedge sys_clk_in);
    chk("flag", 20'(flag), 20'h0);
    $display("test nack done");
    xfer(WLTS_CMD_WRITE, 5'h0a, 16'h003f);
    // host sends exactly the reset key
    xfer(WLTS_CMD_WRITE, 5'h0d, 16'h00a5);
    chk("soft reset", 20'(srst), 20'h1);
    repeat (2) @(negedge sys_clk_in);
    chk("term", 20'(term), 20'h0);
    chk("ladder", ladder, {10'h200, 10'h200});
    $display("test soft reset done");
    end_sim();
  end
  // watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
